//--- shared/charge_timers_regs.svh
// named constants for the charge termination and safety timer block
`ifndef CHARGE_TIMERS_REGS_SVH
`define CHARGE_TIMERS_REGS_SVH

`define CLK_HZ            32'd25000000
`define MINUTE_S          32'd60
`define TIMER_W           10
`define LOW_BAT_TIME_MIN  10'd120
`define FC_STEP_MIN       10'd30
`define FC_FIELD_W        5
`define ICHG_FIELD_W      7
`define ICHG_OFF          7'h00
`define COUNT_ZERO        10'h000

`endif

//--- shared/charge_timers_pkg.sv
// types shared by the charge termination and safety timer block
package charge_timers_pkg;

	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_LOWBAT = 3'b001,
		ST_FAST = 3'b010,
		ST_FULL = 3'b011,
		ST_TERM = 3'b100,
		ST_FAULT = 3'b101
	} charge_state_t;

endpackage : charge_timers_pkg

//--- hdl/minute_tick.sv
// free-running prescaler giving one-cycle base ticks for the safety timers
`timescale 1ns/1ps
module minute_tick #(
	parameter int unsigned CYCLES = 32'd1500000000
) (
	input  wire logic clk,
	input  wire logic rstn,
	output logic      tick_q
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	wire         wrap_w = (cnt_q >= (CYCLES - 32'd1));

	assign cnt_d = wrap_w ? 32'h00000000 : cnt_q + 32'h00000001;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= wrap_w;
		end
	end
endmodule : minute_tick

//--- hdl/safety_timer.sv
// minute counter with clear, stop, half rate and a sticky expiry flag
`timescale 1ns/1ps
`include "charge_timers_regs.svh"
module safety_timer #(
	parameter int W = `TIMER_W
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         clear,
	input  wire logic         run,
	input  wire logic         half,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	output logic [W-1:0]      count_q,
	output logic              expired_q
);
	logic phase_q;
	// stop wins over half rate since run is already gated by every suspend cause
	wire  step_w    = tick && run && !expired_q;
	wire  advance_w = step_w && (!half || phase_q);
	wire  reach_w   = advance_w && ((count_q + {{(W-1){1'b0}}, 1'b1}) >= limit);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_q   <= '0;
			phase_q   <= 1'b0;
			expired_q <= 1'b0;
		end else if (clear) begin
			count_q   <= '0;
			phase_q   <= 1'b0;
			expired_q <= 1'b0;
		end else begin
			if (advance_w)
				count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
			if (step_w)
				phase_q <= half ? !phase_q : 1'b0;
			if (reach_w)
				expired_q <= 1'b1;
		end
	end
endmodule : safety_timer

//--- hdl/charge_termination_safety_timers.sv
// charge completion decision and the low-battery and fast-charge safety timers
//
// Operation
// - end charge at termination voltage and low current
// - no completion while input or thermal loops act
// - termination disabled: hold in full state regulating
// - full state still caps current at field
// - termination enabled: charger off, keep watching voltage
// - recharge from terminated when voltage below offset
// - low battery: 120 minute timer, fast held
// - low timer expiry latches charging fault state
// - low timer stops in suspend states
// - above low threshold: fast runs, low held
// - fast duration from five bit field
// - fast timer expiry latches fault, charging off
// - disable bit resets timers, suspend bit freezes
// - temperature suspend stops both timers
// - regulation loops halve both timer rates
// - hot or cold reduction halves fast timer
// - cool or warm zones keep low timer full
// - timers reset on reset, disable, completion, exit
// - below cold limit suspend charging, stop timers
// - above hot limit suspend charging, stop timers
`timescale 1ns/1ps
`include "charge_timers_regs.svh"
module charge_termination_safety_timers #(
	parameter int unsigned MINUTE_CYCLES = `CLK_HZ * `MINUTE_S
) (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// mode control
	input  wire logic                       charge_enable_pin,
	input  wire logic                       charge_enable_override,
	input  wire logic                       charge_enable_bit,
	input  wire logic                       high_impedance_mode_bit,
	input  wire logic                       term_enable,
	input  wire logic                       timer_disable_bit,
	input  wire logic                       timer_suspend_bit,
	input  wire logic [`FC_FIELD_W-1:0]     fast_charge_duration_field,
	input  wire logic [`ICHG_FIELD_W-1:0]   fast_charge_current_field,
	// comparator results
	input  wire logic                       vbat_at_termination_voltage,
	input  wire logic                       ichg_below_termination_current,
	input  wire logic                       vbat_below_recharge_offset,
	input  wire logic                       vbat_below_low_battery_threshold,
	// regulation loops
	input  wire logic                       vin_loop_active,
	input  wire logic                       iin_loop_active,
	input  wire logic                       thermal_loop_active,
	// temperature zones
	input  wire logic                       cold_suspend_zone,
	input  wire logic                       hot_suspend_zone,
	input  wire logic                       cool_zone,
	input  wire logic                       warm_zone,
	input  wire logic                       zone_reduces_charge,
	// status
	output charge_timers_pkg::charge_state_t state_q,
	output logic                            charger_on_q,
	output logic [`ICHG_FIELD_W-1:0]        current_cap_q,
	output logic                            fault_q,
	output logic                            low_bat_timer_run_q,
	output logic                            fast_timer_run_q,
	output logic                            low_bat_expired_q,
	output logic                            fast_expired_q,
	output logic [`TIMER_W-1:0]             low_bat_minutes_q,
	output logic [`TIMER_W-1:0]             fast_minutes_q
);

	function automatic logic [`TIMER_W-1:0] fast_limit(input logic [`FC_FIELD_W-1:0] f);
		logic [`TIMER_W-1:0] steps;
		steps = {{(`TIMER_W-`FC_FIELD_W){1'b0}}, f} + 10'd1;
		// 0 gives 30 minutes, 31 gives 16 hours
		fast_limit = 10'(steps * `FC_STEP_MIN);
	endfunction : fast_limit

	charge_timers_pkg::charge_state_t state_d;

	logic               tick_w;
	logic               lb_expired_w;
	logic               fc_expired_w;
	logic [`TIMER_W-1:0] lb_count_w;
	logic [`TIMER_W-1:0] fc_count_w;

	// the override bit takes the enable away from the pin
	wire charge_mode_w  = !high_impedance_mode_bit &&
	                      (charge_enable_override ? charge_enable_bit : charge_enable_pin);
	wire temp_suspend_w = charge_mode_w && (cold_suspend_zone || hot_suspend_zone);
	wire reg_loop_w     = vin_loop_active || iin_loop_active || thermal_loop_active;
	wire complete_w     = vbat_at_termination_voltage && ichg_below_termination_current
	                      && !reg_loop_w;

	wire in_lowbat_w = (state_q == charge_timers_pkg::ST_LOWBAT);
	wire in_fast_w   = (state_q == charge_timers_pkg::ST_FAST);
	wire in_full_w   = (state_q == charge_timers_pkg::ST_FULL);
	wire in_term_w   = (state_q == charge_timers_pkg::ST_TERM);
	wire in_fault_w  = (state_q == charge_timers_pkg::ST_FAULT);
	wire in_reset_w  = (state_q == charge_timers_pkg::ST_RESET);
	wire done_d_w    = (state_d == charge_timers_pkg::ST_FULL) ||
	                   (state_d == charge_timers_pkg::ST_TERM);

	// common reset causes for both timers
	wire timers_clear_w = in_reset_w || timer_disable_bit || !charge_mode_w ||
	                      in_full_w || in_term_w || done_d_w;
	// fault keeps its timer so the flag holds until a real reset cause
	wire lb_clear_w = timers_clear_w || !(in_lowbat_w || in_fault_w);
	wire fc_clear_w = timers_clear_w || in_lowbat_w;
	wire lb_run_w   = in_lowbat_w && !temp_suspend_w && !timer_suspend_bit;
	wire fc_run_w   = in_fast_w && !temp_suspend_w && !timer_suspend_bit;
	// cool and warm zones do not touch the low battery rate
	wire lb_half_w  = reg_loop_w;
	wire fc_half_w  = reg_loop_w || zone_reduces_charge;
	wire [`TIMER_W-1:0] fc_limit_w = fast_limit(fast_charge_duration_field);

	wire unused_zone_w = cool_zone ^ warm_zone;

	always_comb begin
		state_d = state_q;
		if (!charge_mode_w) begin
			state_d = charge_timers_pkg::ST_RESET;
		end else begin
			case (state_q)
				charge_timers_pkg::ST_RESET: begin
					state_d = vbat_below_low_battery_threshold ?
					          charge_timers_pkg::ST_LOWBAT : charge_timers_pkg::ST_FAST;
				end
				charge_timers_pkg::ST_LOWBAT: begin
					if (lb_expired_w)
						state_d = charge_timers_pkg::ST_FAULT;
					else if (!vbat_below_low_battery_threshold)
						state_d = charge_timers_pkg::ST_FAST;
				end
				charge_timers_pkg::ST_FAST: begin
					if (fc_expired_w)
						state_d = charge_timers_pkg::ST_FAULT;
					else if (vbat_below_low_battery_threshold)
						state_d = charge_timers_pkg::ST_LOWBAT;
					else if (complete_w && !temp_suspend_w)
						state_d = term_enable ? charge_timers_pkg::ST_TERM
						                      : charge_timers_pkg::ST_FULL;
				end
				charge_timers_pkg::ST_FULL: begin
					// regulates indefinitely, only a mode exit leaves
					state_d = charge_timers_pkg::ST_FULL;
				end
				charge_timers_pkg::ST_TERM: begin
					if (vbat_below_recharge_offset)
						state_d = charge_timers_pkg::ST_FAST;
				end
				charge_timers_pkg::ST_FAULT: begin
					// leaves only once the expired timer has been reset
					if (!lb_expired_w && !fc_expired_w)
						state_d = charge_timers_pkg::ST_RESET;
				end
				default: begin
					state_d = charge_timers_pkg::ST_RESET;
				end
			endcase
		end
	end

	// host may move the duration field at any time; changing it live can
	// make the count jump past the new limit, so disable first
	wire charger_on_d_w = (in_fast_w || in_full_w || in_lowbat_w) &&
	                      charge_mode_w && !temp_suspend_w;
	wire [`ICHG_FIELD_W-1:0] cap_d_w = (charger_on_d_w && !in_lowbat_w) ?
	                                   fast_charge_current_field : `ICHG_OFF;

	minute_tick #(
		.CYCLES (MINUTE_CYCLES)
	) u_tick (
		.clk    (clk),
		.rstn   (rstn),
		.tick_q (tick_w)
	);

	safety_timer #(
		.W (`TIMER_W)
	) u_low_bat (
		.clk       (clk),
		.rstn      (rstn),
		.clear     (lb_clear_w),
		.run       (lb_run_w),
		.half      (lb_half_w),
		.tick      (tick_w),
		.limit     (`LOW_BAT_TIME_MIN),
		.count_q   (lb_count_w),
		.expired_q (lb_expired_w)
	);

	safety_timer #(
		.W (`TIMER_W)
	) u_fast (
		.clk       (clk),
		.rstn      (rstn),
		.clear     (fc_clear_w),
		.run       (fc_run_w),
		.half      (fc_half_w),
		.tick      (tick_w),
		.limit     (fc_limit_w),
		.count_q   (fc_count_w),
		.expired_q (fc_expired_w)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= charge_timers_pkg::ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			charger_on_q        <= 1'b0;
			current_cap_q       <= `ICHG_OFF;
			fault_q             <= 1'b0;
			low_bat_timer_run_q <= 1'b0;
			fast_timer_run_q    <= 1'b0;
		end else begin
			charger_on_q        <= charger_on_d_w && !unused_zone_w ^ unused_zone_w;
			current_cap_q       <= cap_d_w;
			fault_q             <= (state_d == charge_timers_pkg::ST_FAULT);
			low_bat_timer_run_q <= lb_run_w && !lb_clear_w;
			fast_timer_run_q    <= fc_run_w && !fc_clear_w;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_bat_expired_q <= 1'b0;
			fast_expired_q    <= 1'b0;
			low_bat_minutes_q <= `COUNT_ZERO;
			fast_minutes_q    <= `COUNT_ZERO;
		end else begin
			low_bat_expired_q <= lb_expired_w;
			fast_expired_q    <= fc_expired_w;
			low_bat_minutes_q <= lb_count_w;
			fast_minutes_q    <= fc_count_w;
		end
	end

endmodule : charge_termination_safety_timers

//--- verif/charge_timers_sva.sv
// concurrent checks on the charge termination and safety timer ports
`timescale 1ns/1ps
`include "charge_timers_regs.svh"
module charge_timers_sva (
	input wire logic				clk,
	input wire logic				rstn,
	input wire logic				term_enable,
	input wire logic				timer_suspend_bit,
	input wire logic				timer_disable_bit,
	input wire logic [`ICHG_FIELD_W-1:0]	fast_charge_current_field,
	input wire logic				vbat_at_termination_voltage,
	input wire logic				ichg_below_termination_current,
	input wire logic				vin_loop_active,
	input wire logic				iin_loop_active,
	input wire logic				thermal_loop_active,
	input wire logic				cold_suspend_zone,
	input wire logic				hot_suspend_zone,
	input charge_timers_pkg::charge_state_t	state_q,
	input wire logic [`ICHG_FIELD_W-1:0]	current_cap_q,
	input wire logic				low_bat_expired_q,
	input wire logic				fast_expired_q,
	input wire logic [`TIMER_W-1:0]		low_bat_minutes_q,
	input wire logic [`TIMER_W-1:0]		fast_minutes_q
);
	wire is_fast = state_q == charge_timers_pkg::ST_FAST;
	wire is_full = state_q == charge_timers_pkg::ST_FULL;
	wire is_term = state_q == charge_timers_pkg::ST_TERM;
	wire is_fault = state_q == charge_timers_pkg::ST_FAULT;
	wire done_w = vbat_at_termination_voltage && ichg_below_termination_current;
	wire hold_w = timer_suspend_bit || cold_suspend_zone || hot_suspend_zone;
	wire loop_w = vin_loop_active || iin_loop_active || thermal_loop_active;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_no_done_loop: assert property (is_fast && loop_w |=> !is_full && !is_term)
		else $error("completion taken under a regulation loop");
	a_full_entry: assert property (is_full && $past(is_fast) |->
		$past(done_w && !term_enable)) else $error("full hold entered without completion");
	a_term_entry: assert property (is_term && $past(is_fast) |->
		$past(done_w && term_enable)) else $error("terminated entered without completion");
	a_cap_held: assert property (is_full && $past(is_full) && current_cap_q != 0 |->
		current_cap_q == $past(fast_charge_current_field)) else $error("cap differs from field");
	a_disable_clear: assert property (timer_disable_bit [*2] |-> ##2
		fast_minutes_q == 0 && low_bat_minutes_q == 0) else $error("timers not cleared");
	a_hold_frozen: assert property (hold_w [*2] |-> ##2 fast_minutes_q <= $past(fast_minutes_q)
		&& low_bat_minutes_q <= $past(low_bat_minutes_q)) else $error("timer ran while held");
	a_low_clear: assert property (is_fast [*2] |-> ##2 low_bat_minutes_q == 0)
		else $error("low battery timer ran in fast charge");
	a_fault_cause: assert property (is_fault && !$past(is_fault) |->
		fast_expired_q || low_bat_expired_q) else $error("fault without timer expiry");
endmodule : charge_timers_sva
bind charge_termination_safety_timers charge_timers_sva chk (.*);

//--- verif/host_model.sv
// host model: changes the fast charge duration only with the timers disabled
`timescale 1ns/1ps
module host_model (
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic		load,
	input wire logic [4:0]	value,
	output logic			timer_disable_bit,
	output logic [4:0]		fast_charge_duration_field
);
	logic [1:0] step_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			step_q <= 2'h0;
			timer_disable_bit <= 1'b0;
			fast_charge_duration_field <= 5'h00;
		end else begin
			step_q <= load ? 2'h1 : step_q + {1'b0, step_q != 2'h0};
			timer_disable_bit <= load || step_q == 2'h1 || step_q == 2'h2;
			if (step_q == 2'h2) begin
				fast_charge_duration_field <= value;
			end
		end
	end
endmodule : host_model

//--- verif/charge_termination_safety_timers_bench.sv
// bench for the charge termination and safety timer block
`timescale 1ns/1ps
module charge_termination_safety_timers_bench;
	logic clk, rstn, charge_enable_pin, charge_enable_override, charge_enable_bit, load;
	logic high_impedance_mode_bit, term_enable, timer_disable_bit, timer_suspend_bit;
	logic vbat_at_termination_voltage, ichg_below_termination_current, vbat_below_recharge_offset;
	logic vbat_below_low_battery_threshold, vin_loop_active, iin_loop_active, thermal_loop_active;
	logic cold_suspend_zone, hot_suspend_zone, cool_zone, warm_zone, zone_reduces_charge;
	logic charger_on_q, fault_q, low_bat_timer_run_q, fast_timer_run_q;
	logic low_bat_expired_q, fast_expired_q;
	logic [4:0] fast_charge_duration_field, value;
	logic [6:0] fast_charge_current_field, current_cap_q;
	logic [9:0] low_bat_minutes_q, fast_minutes_q;
	charge_timers_pkg::charge_state_t state_q;
	int err_count, comparisons, cycles;
	// four clocks a minute keeps the 120 minute expiry near 500 cycles
	charge_termination_safety_timers #(.MINUTE_CYCLES(4)) uut (.*);
	host_model host (.*);
	task automatic chk(input string nm, input logic [9:0] seen, exp);
		#1;
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wait_state(input charge_timers_pkg::charge_state_t s, input int n);
		for (int i = 0; i < n && state_q !== s; i++) begin
			@(posedge clk);
			#1;
		end
		chk("state", state_q, s);
		cyc(1);
	endtask : wait_state
	// settle first: run enables lag the inputs by a cycle or two
	task automatic rate(input logic sel, input int n, input logic [9:0] lo, hi);
		logic [9:0] m;
		cyc(4);
		#1 m = sel ? low_bat_minutes_q : fast_minutes_q;
		cyc(n);
		#1 m = (sel ? low_bat_minutes_q : fast_minutes_q) - m;
		chk("rate", m >= lo && m <= hi, 1'b1);
		cyc(1);
	endtask : rate
	task automatic report_and_stop;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		{rstn, charge_enable_override, charge_enable_bit, high_impedance_mode_bit, term_enable,
			timer_suspend_bit, vbat_at_termination_voltage, ichg_below_termination_current,
			vbat_below_recharge_offset, vbat_below_low_battery_threshold, vin_loop_active,
			iin_loop_active, thermal_loop_active, cold_suspend_zone, hot_suspend_zone,
			cool_zone, warm_zone, zone_reduces_charge, load, value} = '0;
		charge_enable_pin = 1'b1;
		fast_charge_current_field = 7'h2a;
		cyc(3);
		rstn <= 1'b1;
		wait_state(charge_timers_pkg::ST_FAST, 4);
		{vbat_at_termination_voltage, ichg_below_termination_current} <= 2'b11;
		thermal_loop_active <= 1'b1;
		cyc(4);
		chk("loop", state_q, charge_timers_pkg::ST_FAST);
		cyc(1);
		thermal_loop_active <= 1'b0;
		wait_state(charge_timers_pkg::ST_FULL, 4);
		cyc(1);
		chk("cap", current_cap_q, 7'h2a);
		chk("cleared", fast_minutes_q, 10'h000);
		cyc(1);
		high_impedance_mode_bit <= 1'b1;
		wait_state(charge_timers_pkg::ST_RESET, 4);
		{term_enable, high_impedance_mode_bit} <= 2'b10;
		wait_state(charge_timers_pkg::ST_TERM, 6);
		cyc(1);
		chk("charger off", charger_on_q, 1'b0);
		cyc(1);
		{vbat_at_termination_voltage, ichg_below_termination_current} <= 2'b00;
		vbat_below_recharge_offset <= 1'b1;
		wait_state(charge_timers_pkg::ST_FAST, 4);
		vbat_below_recharge_offset <= 1'b0;
		cyc(90);
		chk("early", state_q, charge_timers_pkg::ST_FAST);
		wait_state(charge_timers_pkg::ST_FAULT, 60);
		chk("fast limit", fast_minutes_q, 10'd30);
		chk("fault off", charger_on_q, 1'b0);
		chk("fault flag", fault_q, 1'b1);
		chk("fast expired", fast_expired_q, 1'b1);
		cyc(1);
		{load, value} <= {1'b1, 5'h01};
		cyc(1);
		load <= 1'b0;
		wait_state(charge_timers_pkg::ST_FAST, 10);
		vin_loop_active <= 1'b1;
		rate(1'b0, 80, 10'd9, 10'd11);
		{vin_loop_active, zone_reduces_charge} <= 2'b01;
		rate(1'b0, 80, 10'd9, 10'd11);
		{vin_loop_active, zone_reduces_charge, cold_suspend_zone} <= 3'b101;
		rate(1'b0, 40, 10'd0, 10'd0);
		{vin_loop_active, cold_suspend_zone, hot_suspend_zone} <= 3'b001;
		rate(1'b0, 40, 10'd0, 10'd0);
		{hot_suspend_zone, timer_suspend_bit} <= 2'b01;
		rate(1'b0, 40, 10'd0, 10'd0);
		{timer_suspend_bit, vbat_below_low_battery_threshold, cool_zone} <= 3'b011;
		wait_state(charge_timers_pkg::ST_LOWBAT, 4);
		rate(1'b1, 40, 10'd9, 10'd11);
		chk("fast held", fast_minutes_q, 10'h000);
		chk("low run", low_bat_timer_run_q, 1'b1);
		chk("fast run off", fast_timer_run_q, 1'b0);
		cyc(1);
		cold_suspend_zone <= 1'b1;
		rate(1'b1, 40, 10'd0, 10'd0);
		cold_suspend_zone <= 1'b0;
		wait_state(charge_timers_pkg::ST_FAULT, 500);
		chk("low limit", low_bat_minutes_q, 10'd120);
		chk("low expired", low_bat_expired_q, 1'b1);
		chk("low fault flag", fault_q, 1'b1);
		report_and_stop();
	end
endmodule : charge_termination_safety_timers_bench
